// file: pkg/adc_fmt_pkg.sv
`default_nettype none
package adc_fmt_pkg;

  // ----------------------------------------------------------------
  // Register port and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 8;
  localparam logic [6:0]  TIMING_ADDR   = 7'h02;
  localparam logic [6:0]  OUTMODE_ADDR  = 7'h03;
  localparam logic [6:0]  DFMT_ADDR     = 7'h04;
  localparam logic [6:0]  STATUS_ADDR   = 7'h05;
  localparam logic [3:0]  TIMING_RST    = 4'h0;
  localparam logic [6:0]  OUTMODE_RST   = 7'h00;
  localparam logic [5:0]  DFMT_RST      = 6'h00;

  // Timing register fields
  localparam int          STAB_BIT      = 0;
  localparam int          PHASE_LSB     = 1;
  localparam int          INV_BIT       = 3;

  // Output mode register fields
  localparam int          FMT_LSB       = 0;
  localparam int          TERM_BIT      = 3;
  localparam int          CUR_LSB       = 4;

  // Data format register fields
  localparam int          TWOS_BIT      = 0;
  localparam int          SCRAM_BIT     = 1;
  localparam int          ALTPOL_BIT    = 2;
  localparam int          TP_LSB        = 3;

  // Output formats
  typedef enum logic [1:0] {
    FMT_FULL     = 2'b00,
    FMT_DDR_DIFF = 2'b01,
    FMT_DDR_SE   = 2'b10,
    FMT_UNUSED   = 2'b11
  } out_fmt_t;

  // Test patterns
  typedef enum logic [2:0] {
    TP_OFF   = 3'b000,
    TP_ZEROS = 3'b001,
    TP_ONES  = 3'b011,
    TP_CHECK = 3'b101,
    TP_ALT   = 3'b111
  } test_pat_t;

  // Codes and patterns, {overflow, sample bits}
  localparam logic [11:0] MIDSCALE      = 12'h800;
  localparam logic [11:0] CODE_MAX      = 12'hfff;
  localparam logic [11:0] CODE_MIN      = 12'h000;
  localparam logic [11:0] ODD_MASK      = 12'haaa;
  localparam logic [12:0] PAT_CHECK_A   = 13'h1555;
  localparam logic [12:0] PAT_CHECK_B   = 13'h0aaa;
  localparam logic [12:0] PAT_ONES      = 13'h1fff;
  localparam logic [12:0] PAT_ZEROS     = 13'h0000;

  // Timing: one sample period spans eight steps of 45 degrees
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          ENC_PERIOD_NS = 800;
  localparam int          STEPS         = ENC_PERIOD_NS / CLK_PERIOD_NS;

  // Driver current in units of 10 uA, and termination boost 16/10
  localparam logic [9:0]  CUR_DEFAULT   = 10'd350;
  localparam int          TERM_MUL      = 16;
  localparam int          TERM_DIV      = 10;

endpackage
`default_nettype wire

// file: logic/adc_output_formatter.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adc_output_formatter
  import adc_fmt_pkg::*;
#(
  parameter int RES_W = 14
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Register port
  input  wire logic [6:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [7:0]       reg_rdata_o,
  // Parallel mode pins
  input  wire logic             par_mode_i,
  input  wire logic             par_fmt_i,
  input  wire logic             par_stab_i,
  // Converter core
  input  wire logic             enc_clk_i,
  input  wire logic [RES_W-1:0] core_result_i,
  // Single-ended outputs
  output logic      [11:0]      sample_bits_o,
  output logic      [5:0]       ddr_bit_pair_lane_o,
  output logic                  overrange_flag_o,
  output logic                  forwarded_clock_true_o,
  output logic                  forwarded_clock_comp_o,
  // Differential outputs
  output logic      [5:0]       lane_p_o,
  output logic      [5:0]       lane_n_o,
  output logic                  overrange_p_o,
  output logic                  overrange_n_o,
  output logic                  fclk_p_o,
  output logic                  fclk_n_o,
  // Driver control
  output logic                  cmos_drive_en_o,
  output logic                  lvds_drive_en_o,
  output logic      [9:0]       driver_current_o,
  output logic                  duty_stabilizer_enable_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Saturate the signed core result into {overflow, offset binary}
  function automatic logic [12:0] sat_code(input logic [RES_W-1:0] r);
    logic signed [RES_W-1:0] v;
    v = $signed(r);
    if (v > $signed(RES_W'(2047)))
      sat_code = {1'b1, CODE_MAX};
    else if (v < $signed(-RES_W'(2048)))
      sat_code = {1'b1, CODE_MIN};
    else
      sat_code = {1'b0, r[11:0] ^ MIDSCALE};
  endfunction

  // Coding, randomizer, polarity, then pattern substitution
  function automatic logic [12:0] fmt_word(
    input logic [12:0] s,
    input logic        twos,
    input logic        rnd,
    input logic        altp,
    input logic [2:0]  tp,
    input logic        alt
  );
    logic [11:0] d;
    d = s[11:0];
    if (twos && !altp)
      d[11] = ~d[11];
    if (rnd)
      d[11:1] = d[11:1] ^ {11{d[0]}};
    if (altp)
      d = d ^ ODD_MASK;
    case (tp)
      TP_ZEROS: fmt_word = PAT_ZEROS;
      TP_ONES:  fmt_word = PAT_ONES;
      TP_CHECK: fmt_word = alt ? PAT_CHECK_B : PAT_CHECK_A;
      TP_ALT:   fmt_word = alt ? PAT_ONES : PAT_ZEROS;
      default:  fmt_word = {s[12], d};
    endcase
  endfunction

  // Driver current code to 10 uA units, boosted by termination
  function automatic logic [9:0] cur_lookup(
    input logic [2:0] code,
    input logic       term
  );
    logic [9:0] base;
    case (code)
      3'b000:  base = 10'd350;
      3'b001:  base = 10'd400;
      3'b010:  base = 10'd450;
      3'b100:  base = 10'd300;
      3'b101:  base = 10'd250;
      3'b110:  base = 10'd210;
      3'b111:  base = 10'd175;
      default: base = CUR_DEFAULT;
    endcase
    if (term)
      cur_lookup = 10'((14'(base) * 14'(TERM_MUL)) / 14'(TERM_DIV));
    else
      cur_lookup = base;
  endfunction

  // Pick the even or odd bit of every lane
  function automatic logic [5:0] lane_pick(
    input logic [11:0] d,
    input logic        odd
  );
    for (int i = 0; i < 6; i++)
      lane_pick[i] = odd ? d[2*i+1] : d[2*i];
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers and sample boundary
  // ----------------------------------------------------------------
  logic             enc_meta_q;
  logic             enc_sync_q;
  logic             enc_prev_q;
  logic [RES_W-1:0] res_meta_q;
  logic [RES_W-1:0] res_sync_q;
  logic [2:0]       par_meta_q;
  logic [2:0]       par_sync_q;
  logic             sample_pulse;

  // Two flops on every pin from outside the clock domain
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      enc_meta_q <= 1'b0;
      enc_sync_q <= 1'b0;
      enc_prev_q <= 1'b0;
      res_meta_q <= '0;
      res_sync_q <= '0;
      par_meta_q <= 3'h0;
      par_sync_q <= 3'h0;
    end
    else
    begin
      enc_meta_q <= enc_clk_i;
      enc_sync_q <= enc_meta_q;
      enc_prev_q <= enc_sync_q;
      res_meta_q <= core_result_i;
      res_sync_q <= res_meta_q;
      par_meta_q <= {par_stab_i, par_fmt_i, par_mode_i};
      par_sync_q <= par_meta_q;
    end
  end

  // Rising encode edge marks a sample boundary
  assign sample_pulse = enc_sync_q & ~enc_prev_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] timing_q;
  logic [6:0] outmode_q;
  logic [5:0] dfmt_q;
  logic       wr_timing;
  logic       wr_outmode;
  logic       wr_dfmt;
  logic [7:0] rdata_d;
  logic [7:0] status_word;

  assign wr_timing  = reg_wr_i && (reg_addr_i == TIMING_ADDR);
  assign wr_outmode = reg_wr_i && (reg_addr_i == OUTMODE_ADDR);
  assign wr_dfmt    = reg_wr_i && (reg_addr_i == DFMT_ADDR);

  // Software writes to the mode registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      timing_q  <= TIMING_RST;
      outmode_q <= OUTMODE_RST;
      dfmt_q    <= DFMT_RST;
    end
    else
    begin
      if (wr_timing)
        timing_q <= reg_wdata_i[3:0];
      if (wr_outmode)
        outmode_q <= reg_wdata_i[6:0];
      if (wr_dfmt)
        dfmt_q <= reg_wdata_i[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Effective settings
  // ----------------------------------------------------------------
  logic       par_mode;
  out_fmt_t   eff_fmt;
  logic [1:0] eff_phase;
  logic       eff_inv;
  logic       eff_twos;
  logic       eff_scram;
  logic       eff_altpol;
  logic [2:0] eff_tp;
  logic [2:0] eff_cur;
  logic       eff_term;
  logic       eff_stab;

  // Pin mode offers only full rate or DDR differential
  assign par_mode  = par_sync_q[0];
  assign eff_fmt   = par_mode ? (par_sync_q[1] ? FMT_DDR_DIFF : FMT_FULL)
                   : (outmode_q[FMT_LSB+:2] == FMT_UNUSED) ? FMT_FULL
                   : out_fmt_t'(outmode_q[FMT_LSB+:2]);
  assign eff_phase = par_mode ? 2'b00 : timing_q[PHASE_LSB+:2];
  assign eff_inv   = par_mode ? 1'b0 : timing_q[INV_BIT];
  assign eff_stab  = par_mode ? par_sync_q[2] : timing_q[STAB_BIT];
  assign eff_twos  = !par_mode && dfmt_q[TWOS_BIT];
  assign eff_scram = !par_mode && dfmt_q[SCRAM_BIT];
  assign eff_altpol = !par_mode && dfmt_q[ALTPOL_BIT];
  assign eff_tp    = par_mode ? TP_OFF : dfmt_q[TP_LSB+:3];
  assign eff_cur   = par_mode ? 3'b000 : outmode_q[CUR_LSB+:3];
  assign eff_term  = !par_mode && outmode_q[TERM_BIT];

  // ----------------------------------------------------------------
  // Sample pipeline and phase counter
  // ----------------------------------------------------------------
  out_fmt_t   act_fmt_q;
  logic [1:0] act_phase_q;
  logic       act_inv_q;
  logic [12:0] word_q;
  logic [12:0] sat_now;
  logic [12:0] word_d;
  logic        alt_q;
  logic [2:0]  ph_q;

  assign sat_now = sat_code(res_sync_q);
  assign word_d  = fmt_word(sat_now, eff_twos, eff_scram, eff_altpol,
                            eff_tp, alt_q);

  // Word and settings latch together at each sample boundary
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      act_fmt_q   <= FMT_FULL;
      act_phase_q <= 2'b00;
      act_inv_q   <= 1'b0;
      word_q      <= 13'h0000;
      alt_q       <= 1'b0;
      ph_q        <= 3'h0;
    end
    else if (sample_pulse)
    begin
      act_fmt_q   <= eff_fmt;
      act_phase_q <= eff_phase;
      act_inv_q   <= eff_inv;
      word_q      <= word_d;
      alt_q       <= ~alt_q;
      ph_q        <= 3'h0;
    end
    else
      ph_q <= ph_q + 3'h1;
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic [2:0] ph_shift;
  logic       fclk_lvl;
  logic [5:0] lanes;
  logic       is_full;
  logic       is_diff;

  // Clock delayed in eighth-period steps, then optionally inverted
  assign ph_shift = ph_q - {1'b0, act_phase_q};
  assign fclk_lvl = ph_shift[2] ^ act_inv_q;
  assign lanes    = lane_pick(word_q[11:0], ph_q[2]);
  assign is_full  = (act_fmt_q == FMT_FULL);
  assign is_diff  = (act_fmt_q == FMT_DDR_DIFF);

  // Drive the pins of the selected format, others held low
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sample_bits_o          <= 12'h000;
      ddr_bit_pair_lane_o    <= 6'h00;
      overrange_flag_o       <= 1'b0;
      forwarded_clock_true_o <= 1'b0;
      forwarded_clock_comp_o <= 1'b0;
      lane_p_o               <= 6'h00;
      lane_n_o               <= 6'h00;
      overrange_p_o          <= 1'b0;
      overrange_n_o          <= 1'b0;
      fclk_p_o               <= 1'b0;
      fclk_n_o               <= 1'b0;
      cmos_drive_en_o        <= 1'b0;
      lvds_drive_en_o        <= 1'b0;
    end
    else
    begin
      sample_bits_o          <= is_full ? word_q[11:0] : 12'h000;
      ddr_bit_pair_lane_o    <= (!is_full && !is_diff) ? lanes : 6'h00;
      overrange_flag_o       <= !is_diff && word_q[12];
      forwarded_clock_true_o <= !is_diff && fclk_lvl;
      forwarded_clock_comp_o <= !is_diff && !fclk_lvl;
      lane_p_o               <= is_diff ? lanes : 6'h00;
      lane_n_o               <= is_diff ? ~lanes : 6'h00;
      overrange_p_o          <= is_diff && word_q[12];
      overrange_n_o          <= is_diff && !word_q[12];
      fclk_p_o               <= is_diff && fclk_lvl;
      fclk_n_o               <= is_diff && !fclk_lvl;
      cmos_drive_en_o        <= !is_diff;
      lvds_drive_en_o        <= is_diff;
    end
  end

  // Driver current and stabilizer follow the effective settings directly
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      driver_current_o         <= CUR_DEFAULT;
      duty_stabilizer_enable_o <= 1'b0;
    end
    else
    begin
      driver_current_o         <= cur_lookup(eff_cur, eff_term);
      duty_stabilizer_enable_o <= eff_stab;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  assign status_word = {3'h0, par_mode, act_fmt_q, fclk_lvl, word_q[12]};
  assign rdata_d = (reg_addr_i == TIMING_ADDR)  ? {4'h0, timing_q}
                 : (reg_addr_i == OUTMODE_ADDR) ? {1'b0, outmode_q}
                 : (reg_addr_i == DFMT_ADDR)    ? {2'h0, dfmt_q}
                 : (reg_addr_i == STATUS_ADDR)  ? status_word
                 : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= reg_rd_i ? rdata_d : 8'h00;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  pin_mode_fmt_a: assert property (
    par_mode |-> eff_fmt != FMT_DDR_SE)
    else $error("pin mode selected single-ended DDR");

  clock_pair_a: assert property (
    !is_diff ##1 1 |-> forwarded_clock_true_o != forwarded_clock_comp_o)
    else $error("forwarded clock pair not complementary");

  ddr_even_low_a: assert property (
    (act_fmt_q == FMT_DDR_SE && act_phase_q == 2'b00 && !act_inv_q
     && !sample_pulse)
    |=> ddr_bit_pair_lane_o == lane_pick($past(word_q[11:0]),
                                         forwarded_clock_true_o))
    else $error("DDR lane bit does not match clock level");

  term_boost_a: assert property (
    (!par_mode && outmode_q[6:3] == 4'b0001)
    |=> driver_current_o == 10'd560)
    else $error("termination did not boost driver current");

  saturate_top_a: assert property (
    (sample_pulse && $signed(res_sync_q) > $signed(RES_W'(2047))
     && eff_tp == TP_OFF && !eff_twos && !eff_scram && !eff_altpol)
    |=> word_q == {1'b1, CODE_MAX})
    else $error("overrange sample not saturated with overflow");

  twos_msb_a: assert property (
    (sample_pulse && eff_twos && !eff_scram && !eff_altpol
     && eff_tp == TP_OFF)
    |=> word_q[11] == !$past(sat_now[11]))
    else $error("two's complement did not invert the MSB");

  pattern_ones_a: assert property (
    (sample_pulse && eff_tp == TP_ONES) |=> word_q == PAT_ONES)
    else $error("all-ones pattern not forced");

  settings_hold_a: assert property (
    !sample_pulse |=> $stable(act_fmt_q) && $stable(act_phase_q))
    else $error("settings changed inside a sample");

  clock_shift_a: assert property (
    (sample_pulse && !eff_inv && eff_fmt == FMT_FULL)
    |=> ##1 forwarded_clock_true_o == (eff_phase != 2'b00) [*1])
    else $error("forwarded clock shift wrong at sample start");

endmodule
`default_nettype wire

// file: tb/fmt_capture.sv
`timescale 1ns/10ps
`default_nettype none
module fmt_capture
(
  // Clock
  input  wire logic        clk_i,
  // Link from the formatter
  input  wire logic        fclk_i,
  input  wire logic        ddr_i,
  input  wire logic [11:0] bits_i,
  input  wire logic [5:0]  lanes_i,
  input  wire logic        of_i,
  // Receiver decode settings
  input  wire logic        rnd_i,
  input  wire logic        altpol_i,
  // Captured word
  output logic      [11:0] raw_o,
  output logic      [11:0] word_o,
  output logic             of_o,
  output logic             valid_o
);
  logic        fclk_q;
  logic        of_q;
  logic [5:0]  lanes_q;
  logic [5:0]  even_q;
  logic [11:0] raw_w;
  logic [11:0] altpol_w;
  logic        rise_w;
  logic        fall_w;

  // Even bits come from the low phase, odd bits from the high phase
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      raw_w[2*i]   = even_q[i];
      raw_w[2*i+1] = lanes_q[i];
    end
    if (!ddr_i)
      raw_w = bits_i;
  end

  // Edge detect and odd-bit restore
  assign rise_w = fclk_i && !fclk_q;
  assign fall_w = !fclk_i && fclk_q;
  assign altpol_w = raw_w ^ (altpol_i ? 12'haaa : 12'h000);

  // Capture on the rising clock, or after the high phase in DDR
  always_ff @(posedge clk_i)
  begin
    fclk_q  <= fclk_i;
    lanes_q <= lanes_i;
    of_q    <= of_i;
    valid_o <= 1'b0;
    if (rise_w)
      even_q <= lanes_q;
    if (ddr_i ? fall_w : rise_w)
    begin
      raw_o   <= raw_w;
      word_o  <= altpol_w ^ (rnd_i ? {{11{altpol_w[0]}}, 1'b0} : 12'h000);
      of_o    <= ddr_i ? of_q : of_i;
      valid_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: tb/adc_output_formatter_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_output_formatter_tb
  import adc_fmt_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk    = 1'b0;
  logic        srst   = 1'b1;
  logic        enc    = 1'b0;
  logic [6:0]  addr   = 7'h00;
  logic [7:0]  wdata  = 8'h00;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        pmode  = 1'b0;
  logic        pfmt   = 1'b0;
  logic        pdcs   = 1'b0;
  logic [13:0] res    = 14'h0000;
  logic        tog    = 1'b0;
  logic [1:0]  fmt    = 2'b00;
  logic        rx_rnd = 1'b0;
  logic        rx_altpol = 1'b0;
  int          res_a  = 0;
  int          res_b  = 0;
  int          err_total = 0;
  int          checks = 0;
  logic [7:0]  rdata;
  logic [11:0] bits, raw, word;
  logic [5:0]  lanes, lp, ln;
  logic        of_se, fct, fcc, ofp, ofn, fp, fn;
  logic        cmos_en, lvds_en, stab_en, rx_of, rx_vld;
  logic [9:0]  cur;
  wire         ddiff  = (fmt == 2'b01);
  wire         rx_fclk = ddiff ? fp : fct;
  wire [5:0]   rx_lanes = ddiff ? lp : lanes;
  wire         rx_ofin = ddiff ? ofp : of_se;
  wire         rx_ddr = (fmt != 2'b00);

  // Clocks: system 100 ns, encode 800 ns at an unrelated phase
  always #50 clk = ~clk;
  initial
  begin
    #37;
    forever #400 enc = ~enc;
  end

  // Alternate two results on successive samples, away from the rise
  always @(negedge enc)
  begin
    @(posedge clk);
    tog <= ~tog;
    res <= 14'(tog ? res_b : res_a);
  end

  adc_output_formatter dut (
    .clk_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .par_mode_i(pmode),
    .par_fmt_i(pfmt), .par_stab_i(pdcs), .enc_clk_i(enc),
    .core_result_i(res), .sample_bits_o(bits), .ddr_bit_pair_lane_o(lanes),
    .overrange_flag_o(of_se), .forwarded_clock_true_o(fct),
    .forwarded_clock_comp_o(fcc), .lane_p_o(lp), .lane_n_o(ln),
    .overrange_p_o(ofp), .overrange_n_o(ofn), .fclk_p_o(fp), .fclk_n_o(fn),
    .cmos_drive_en_o(cmos_en), .lvds_drive_en_o(lvds_en),
    .driver_current_o(cur), .duty_stabilizer_enable_o(stab_en));

  fmt_capture rx (
    .clk_i(clk), .fclk_i(rx_fclk), .ddr_i(rx_ddr), .bits_i(bits),
    .lanes_i(rx_lanes), .of_i(rx_ofin), .rnd_i(rx_rnd), .altpol_i(rx_altpol),
    .raw_o(raw), .word_o(word), .of_o(rx_of), .valid_o(rx_vld));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [6:0] a, output logic [7:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  // Skip n captured words, keeping the last one
  task automatic get_word(input int n);
    int i;
    repeat (n)
    begin
      i = 0;
      do
      begin
        @(posedge clk);
        i++;
      end while (rx_vld !== 1'b1 && i < 40);
      if (rx_vld !== 1'b1)
      begin
        err_total++;
        test_done();
      end
    end
  endtask

  // Expected {overflow, bits} from a result and the coding settings
  function automatic logic [12:0] enc_word(input int r, input logic tw,
                                           input logic rn, input logic ab);
    logic [11:0] c;
    logic        o;
    o = (r > 2047) || (r < -2048);
    c = r > 2047 ? 12'hfff : r < -2048 ? 12'h000 : 12'(r + 2048);
    if (tw && !ab)
      c[11] = ~c[11];
    if (rn)
      c[11:1] = c[11:1] ^ {11{c[0]}};
    if (ab)
      c = c ^ 12'haaa;
    return {o, c};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_current();
    int         tbl [8] = '{350, 400, 450, 350, 300, 250, 210, 175};
    logic [7:0] v;
    fmt = 2'b01;
    for (int t = 0; t < 2; t++)
      for (int c = 0; c < 8; c++)
      begin
        wr_reg(OUTMODE_ADDR, {1'b0, 3'(c), t[0], 3'b001});
        get_word(2);
        chk(16'(cur), 16'(t ? tbl[c] * 16 / 10 : tbl[c]));
      end
    rd_reg(OUTMODE_ADDR, v);
    chk(16'(v), 16'h0079);
    rd_reg(7'h10, v);
    chk(16'(v), 16'h0000);
    chk(16'(lvds_en), 16'h0001);
  endtask

  task automatic t_data();
    int vals [7] = '{0, 5, 2047, 3000, -2048, -3000, -1};
    for (int f = 0; f < 3; f++)
    begin
      fmt = f == 0 ? 2'b00 : f == 1 ? 2'b10 : 2'b01;
      wr_reg(OUTMODE_ADDR, {6'h00, fmt});
      foreach (vals[i])
      begin
        res_a = vals[i];
        res_b = vals[i];
        get_word(4);
        chk({3'b000, rx_of, word}, 16'(enc_word(vals[i], 0, 0, 0)));
      end
      chk(16'(lp ^ ln), 16'(ddiff ? 6'h3f : 6'h00));
      chk(16'(ofp ^ ofn), 16'(ddiff));
      chk(16'(fp ^ fn), 16'(ddiff));
      chk(16'(cmos_en), 16'(!ddiff));
    end
  endtask

  task automatic t_coding();
    logic [12:0] e;
    fmt = 2'b00;
    wr_reg(OUTMODE_ADDR, 8'h00);
    res_a = -1233;
    res_b = -1233;
    for (int m = 0; m < 8; m++)
    begin
      rx_rnd = m[1];
      rx_altpol = m[2];
      wr_reg(DFMT_ADDR, 8'(m));
      get_word(4);
      e = enc_word(-1233, m[0], m[1], m[2]);
      chk(16'(raw), 16'(e[11:0]));
      chk(16'(word), 16'(enc_word(-1233, m[0] & ~m[2], 0, 0)));
      chk(16'(rx_of), 16'h0000);
    end
  endtask

  task automatic t_pattern();
    logic [12:0] w1;
    logic [2:0]  tp [4] = '{3'b001, 3'b011, 3'b101, 3'b111};
    logic [12:0] hi [4] = '{13'h0000, 13'h1fff, 13'h1555, 13'h1fff};
    logic [12:0] lo [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h0000};
    rx_rnd = 1'b0;
    rx_altpol = 1'b0;
    foreach (tp[i])
    begin
      wr_reg(DFMT_ADDR, {2'b00, tp[i], 3'b111});
      get_word(4);
      w1 = {rx_of, raw};
      get_word(1);
      chk(16'(w1 ^ {rx_of, raw}), 16'(i < 2 ? 13'h0000 : 13'h1fff));
      chk(16'(w1), 16'(w1[12] === 1'b1 ? hi[i] : lo[i]));
    end
  endtask

  task automatic t_phase();
    logic [11:0] prev;
    int          n;
    res_a = 0;
    res_b = 1;
    wr_reg(DFMT_ADDR, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      wr_reg(TIMING_ADDR, {4'h0, k[2], k[1:0], 1'b1});
      get_word(3);
      prev = bits;
      n = 0;
      while (bits === prev && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 20)
      begin
        err_total++;
        test_done();
      end
      n = 0;
      while (fct !== k[2] && n < 9)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 9)
      begin
        err_total++;
        test_done();
      end
      chk(16'(n), 16'(k[1:0]));
      chk(16'(fct ^ fcc), 16'h0001);
    end
    chk(16'(stab_en), 16'h0001);
  endtask

  task automatic t_pins();
    pmode <= 1'b1;
    pfmt  <= 1'b1;
    pdcs  <= 1'b1;
    repeat (20) @(posedge clk);
    chk(16'({lvds_en, cmos_en, stab_en}), 16'h0005);
    chk(16'(cur), 16'd350);
    pfmt  <= 1'b0;
    repeat (20) @(posedge clk);
    chk(16'({lvds_en, cmos_en}), 16'h0001);
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(16'(cur), 16'd350);
    chk(16'(bits), 16'h0000);
    t_current();
    t_data();
    t_coding();
    t_pattern();
    t_phase();
    t_pins();
    test_done();
  end
endmodule
`default_nettype wire
